// File: src/pin_reuse_gpio.sv
// Multi-use pin GPIO, debug output pin mux and revision register
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps

// Functional notes
// - Output enable register turns pins into GPIO
// - Clock pin GPIO enable replaces clock output
// - Scan pin enables ignored when scan active
// - Output value register sets driven pin levels
// - Input register returns synchronised pin levels
// - Control register: select, pad speed, reserved bits
// - Select 0-3: tri-state, tri-state, low, high
// - Select 4-6: TX envelope, TX active, generic
// - Select 7-9: RX envelope, RX active, RX bits
// - Pad speed bit selects fast pad switching
// - Read-only revision holds version and subversion
module pin_reuse_gpio #(
  parameter logic [3:0] SILICON_VERSION = pin_reuse_pkg::SILICON_VERSION_DEF,
  parameter logic [3:0] SILICON_SUBVERSION = pin_reuse_pkg::SILICON_SUBVERSION_DEF,
  parameter int PIN_COUNT = pin_reuse_pkg::PIN_COUNT
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Register port
  input wire logic [pin_reuse_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [pin_reuse_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [pin_reuse_pkg::DATA_W-1:0] reg_rdata_o,
  // Multi-use pins, bit order: signal input, clock, straps high/low, TCK, TMS, TDI, TDO
  input wire logic [PIN_COUNT-1:0] pin_in_i,
  output logic [PIN_COUNT-1:0] pin_out_o,
  output logic [PIN_COUNT-1:0] pin_oe_o,
  // Core functions sharing the pins
  input wire logic boundary_scan_active_i,
  input wire logic clock_output_i,
  output logic clock_pin_gpio_enable_o,
  // Debug output pin
  input wire pin_reuse_pkg::monitor_sig_t monitor_sig_i,
  output logic debug_output_pin_o,
  output logic debug_output_pin_oe_o,
  // Pad mode
  output logic fast_pad_switching_o
);

  if (PIN_COUNT != pin_reuse_pkg::DATA_W) begin : g_bad_width
    $error("PIN_COUNT must equal the 8-bit register width");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [PIN_COUNT-1:0] pin_output_enable_ff;
  logic [PIN_COUNT-1:0] pin_output_value_ff;
  logic [3:0] monitor_select_ff;
  logic fast_pad_switching_ff;
  wire [PIN_COUNT-1:0] pin_input_level;
  wire [PIN_COUNT-1:0] pad_out;
  wire [PIN_COUNT-1:0] pad_oe;
  logic [pin_reuse_pkg::DATA_W-1:0] reg_rdata_ff;
  logic debug_out_ff;
  logic debug_oe_ff;

  wire sel_enable = reg_addr_i == pin_reuse_pkg::PIN_OUTPUT_ENABLE_OFS;
  wire sel_value = reg_addr_i == pin_reuse_pkg::PIN_OUTPUT_VALUE_OFS;
  wire sel_input = reg_addr_i == pin_reuse_pkg::PIN_INPUT_LEVEL_OFS;
  wire sel_control = reg_addr_i == pin_reuse_pkg::DEBUG_OUTPUT_CONTROL_OFS;
  wire sel_revision = reg_addr_i == pin_reuse_pkg::SILICON_REVISION_OFS;

  wire [7:0] control_rd = {fast_pad_switching_ff, 3'h0, monitor_select_ff};
  wire [7:0] revision_rd = {SILICON_VERSION, SILICON_SUBVERSION};

  // Unmapped addresses read as zero
  wire [7:0] nxt_rdata = sel_enable ? pin_output_enable_ff :
                         sel_value ? pin_output_value_ff :
                         sel_input ? pin_input_level :
                         sel_control ? control_rd :
                         sel_revision ? revision_rd : 8'h00;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pin_output_enable_ff <= pin_reuse_pkg::PIN_OUTPUT_ENABLE_RST;
      pin_output_value_ff <= pin_reuse_pkg::PIN_OUTPUT_VALUE_RST;
      monitor_select_ff <= pin_reuse_pkg::MONITOR_SELECT_RST;
      fast_pad_switching_ff <= pin_reuse_pkg::FAST_PAD_RST;
    end else if (reg_wr_i) begin
      if (sel_enable) pin_output_enable_ff <= reg_wdata_i;
      if (sel_value) pin_output_value_ff <= reg_wdata_i;
      if (sel_control) begin
        monitor_select_ff <= reg_wdata_i[3:0];
        fast_pad_switching_ff <= reg_wdata_i[pin_reuse_pkg::FAST_PAD_BIT];
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) reg_rdata_ff <= 8'h00;
    else reg_rdata_ff <= reg_rd_i ? nxt_rdata : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pad drive

  // Scan pins stay with the scan logic while it owns them
  wire [7:0] scan_mask = boundary_scan_active_i ? 8'h0F : 8'h00;
  wire [7:0] eff_enable = pin_output_enable_ff & ~scan_mask;
  wire clock_gpio = pin_output_enable_ff[pin_reuse_pkg::CLOCK_PIN_BIT];

  // Clock pin is driven by the clock function unless taken over as GPIO
  wire [7:0] nxt_pad_oe = eff_enable | {1'b0, ~clock_gpio, 6'h00};
  wire [7:0] nxt_pad_out = {pin_output_value_ff[7],
                            clock_gpio ? pin_output_value_ff[6] : clock_output_i,
                            pin_output_value_ff[5:0]};

  // Next drive of all pads, registered inside the pin slices
  pin_reuse_pkg::pad_drive_t nxt_pad;
  assign nxt_pad = {nxt_pad_oe, nxt_pad_out};

  ////////////////////////////////////////////////////////////////////////////////
  // Pin slices, one per multi-use pin, most significant bit first

  // Signal input pin
  pin_pad_slice signal_in_slice (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .pad_level_i(pin_in_i[7]),
    .pad_out_o(pad_out[7]),
    .pad_oe_o(pad_oe[7]),
    .drive_out_i(nxt_pad.out[7]),
    .drive_oe_i(nxt_pad.oe[7]),
    .level_o(pin_input_level[7])
  );

  // Clock output pin
  pin_pad_slice clock_pin_slice (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .pad_level_i(pin_in_i[6]),
    .pad_out_o(pad_out[6]),
    .pad_oe_o(pad_oe[6]),
    .drive_out_i(nxt_pad.out[6]),
    .drive_oe_i(nxt_pad.oe[6]),
    .level_o(pin_input_level[6])
  );

  // Interface strap, high
  pin_pad_slice strap_high_slice (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .pad_level_i(pin_in_i[5]),
    .pad_out_o(pad_out[5]),
    .pad_oe_o(pad_oe[5]),
    .drive_out_i(nxt_pad.out[5]),
    .drive_oe_i(nxt_pad.oe[5]),
    .level_o(pin_input_level[5])
  );

  // Interface strap, low
  pin_pad_slice strap_low_slice (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .pad_level_i(pin_in_i[4]),
    .pad_out_o(pad_out[4]),
    .pad_oe_o(pad_oe[4]),
    .drive_out_i(nxt_pad.out[4]),
    .drive_oe_i(nxt_pad.oe[4]),
    .level_o(pin_input_level[4])
  );

  // Scan clock pin
  pin_pad_slice scan_clock_slice (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .pad_level_i(pin_in_i[3]),
    .pad_out_o(pad_out[3]),
    .pad_oe_o(pad_oe[3]),
    .drive_out_i(nxt_pad.out[3]),
    .drive_oe_i(nxt_pad.oe[3]),
    .level_o(pin_input_level[3])
  );

  // Scan mode select pin
  pin_pad_slice scan_mode_slice (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .pad_level_i(pin_in_i[2]),
    .pad_out_o(pad_out[2]),
    .pad_oe_o(pad_oe[2]),
    .drive_out_i(nxt_pad.out[2]),
    .drive_oe_i(nxt_pad.oe[2]),
    .level_o(pin_input_level[2])
  );

  // Scan data input pin
  pin_pad_slice scan_din_slice (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .pad_level_i(pin_in_i[1]),
    .pad_out_o(pad_out[1]),
    .pad_oe_o(pad_oe[1]),
    .drive_out_i(nxt_pad.out[1]),
    .drive_oe_i(nxt_pad.oe[1]),
    .level_o(pin_input_level[1])
  );

  // Scan data output pin
  pin_pad_slice scan_dout_slice (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .pad_level_i(pin_in_i[0]),
    .pad_out_o(pad_out[0]),
    .pad_oe_o(pad_oe[0]),
    .drive_out_i(nxt_pad.out[0]),
    .drive_oe_i(nxt_pad.oe[0]),
    .level_o(pin_input_level[0])
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Debug output pin

  logic nxt_dbg_out;
  logic nxt_dbg_oe;

  always_comb begin
    nxt_dbg_out = 1'b0;
    nxt_dbg_oe = 1'b1;
    case (monitor_select_ff)
      pin_reuse_pkg::MON_LOW: nxt_dbg_out = 1'b0;
      pin_reuse_pkg::MON_HIGH: nxt_dbg_out = 1'b1;
      pin_reuse_pkg::MON_TX_ENVELOPE: nxt_dbg_out = monitor_sig_i.tx_envelope;
      pin_reuse_pkg::MON_TX_ACTIVE: nxt_dbg_out = monitor_sig_i.tx_active;
      pin_reuse_pkg::MON_GENERIC: nxt_dbg_out = monitor_sig_i.generic_internal_debug_signal;
      pin_reuse_pkg::MON_RX_ENVELOPE: nxt_dbg_out = monitor_sig_i.rx_envelope;
      pin_reuse_pkg::MON_RX_ACTIVE: nxt_dbg_out = monitor_sig_i.rx_active;
      pin_reuse_pkg::MON_RX_BITS: nxt_dbg_out = monitor_sig_i.rx_bits;
      // Codes 0, 1 and A-F leave the pin floating
      default: nxt_dbg_oe = 1'b0;
    endcase
  end

  // Registered debug pin: one cycle of lag traded for a glitch-free pin
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      debug_out_ff <= 1'b0;
      debug_oe_ff <= 1'b0;
    end else begin
      debug_out_ff <= nxt_dbg_out;
      debug_oe_ff <= nxt_dbg_oe;
    end
  end

  assign reg_rdata_o = reg_rdata_ff;
  assign pin_oe_o = pad_oe;
  assign pin_out_o = pad_out;
  assign clock_pin_gpio_enable_o = clock_gpio;
  assign debug_output_pin_o = debug_out_ff;
  assign debug_output_pin_oe_o = debug_oe_ff;
  assign fast_pad_switching_o = fast_pad_switching_ff;

endmodule : pin_reuse_gpio

////////////////////////////////////////////////////////////////////////////////
// One multi-use pin: two-stage input synchroniser and registered pad drive
module pin_pad_slice #(
  parameter int SYNC_STAGES = 2
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Pad side
  input wire logic pad_level_i,
  output logic pad_out_o,
  output logic pad_oe_o,
  // Core side
  input wire logic drive_out_i,
  input wire logic drive_oe_i,
  output logic level_o
);

  if (SYNC_STAGES != 2) begin : g_bad_stages
    $error("SYNC_STAGES must be 2: the synchroniser has two fixed stages");
  end

  logic sync1_ff;
  logic sync2_ff;
  logic pad_out_ff;
  logic pad_oe_ff;

  // Pin is asynchronous; the first stage may go metastable, so only the second is read
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= pad_level_i;
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pad_out_ff <= 1'b0;
      pad_oe_ff <= 1'b0;
    end else begin
      pad_out_ff <= drive_out_i;
      pad_oe_ff <= drive_oe_i;
    end
  end

  assign level_o = sync2_ff;
  assign pad_out_o = pad_out_ff;
  assign pad_oe_o = pad_oe_ff;

endmodule : pin_pad_slice

// File: src/pin_reuse_pkg.sv
// Package: register map, field layout and types of the multi-use pin block
package pin_reuse_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int PIN_COUNT = 8;

  // Register offsets
  localparam logic [7:0] PIN_OUTPUT_ENABLE_OFS = 8'h44;
  localparam logic [7:0] PIN_OUTPUT_VALUE_OFS = 8'h45;
  localparam logic [7:0] PIN_INPUT_LEVEL_OFS = 8'h46;
  localparam logic [7:0] DEBUG_OUTPUT_CONTROL_OFS = 8'h47;
  localparam logic [7:0] SILICON_REVISION_OFS = 8'h7F;

  // Field positions
  localparam int CLOCK_PIN_BIT = 6;
  localparam int SCAN_PIN_HI = 3;
  localparam int SCAN_PIN_LO = 0;
  localparam int MONITOR_SELECT_HI = 3;
  localparam int MONITOR_SELECT_LO = 0;
  localparam int FAST_PAD_BIT = 7;

  // Reset values
  localparam logic [7:0] PIN_OUTPUT_ENABLE_RST = 8'h00;
  localparam logic [7:0] PIN_OUTPUT_VALUE_RST = 8'h00;
  localparam logic [3:0] MONITOR_SELECT_RST = 4'h0;
  localparam logic FAST_PAD_RST = 1'b0;

  // Identity values, arbitrary
  localparam logic [3:0] SILICON_VERSION_DEF = 4'h3;
  localparam logic [3:0] SILICON_SUBVERSION_DEF = 4'h5;

  // Monitor select codes
  localparam logic [3:0] MON_TRISTATE_A = 4'h0;
  localparam logic [3:0] MON_TRISTATE_B = 4'h1;
  localparam logic [3:0] MON_LOW = 4'h2;
  localparam logic [3:0] MON_HIGH = 4'h3;
  localparam logic [3:0] MON_TX_ENVELOPE = 4'h4;
  localparam logic [3:0] MON_TX_ACTIVE = 4'h5;
  localparam logic [3:0] MON_GENERIC = 4'h6;
  localparam logic [3:0] MON_RX_ENVELOPE = 4'h7;
  localparam logic [3:0] MON_RX_ACTIVE = 4'h8;
  localparam logic [3:0] MON_RX_BITS = 4'h9;

  // Internal signals offered to the debug output pin
  typedef struct packed {
    logic tx_envelope;
    logic tx_active;
    logic generic_internal_debug_signal;
    logic rx_envelope;
    logic rx_active;
    logic rx_bits;
  } monitor_sig_t;

  // Drive enables and levels of all multi-use pins
  typedef struct packed {
    logic [PIN_COUNT-1:0] oe;
    logic [PIN_COUNT-1:0] out;
  } pad_drive_t;

endpackage : pin_reuse_pkg

// File: testbench/pin_reuse_gpio_checker.sv
// Checker: port-level properties of the multi-use pin block
`timescale 1ns/1ps
module pin_reuse_gpio_checker #(
  parameter logic [3:0] SILICON_VERSION = 4'h0,
  parameter logic [3:0] SILICON_SUBVERSION = 4'h0
) (
  // Clock, reset and register port
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // Pins and shared functions
  input wire logic [7:0] pin_out_o,
  input wire logic [7:0] pin_oe_o,
  input wire logic boundary_scan_active_i,
  input wire logic clock_output_i,
  input wire logic clock_pin_gpio_enable_o,
  input wire pin_reuse_pkg::monitor_sig_t monitor_sig_i,
  input wire logic debug_output_pin_o,
  input wire logic debug_output_pin_oe_o,
  input wire logic fast_pad_switching_o
);
  // Shadow of the select field, delayed to line up with the pad stage
  logic [3:0] sel_ff;
  logic [3:0] sel_d_ff;
  logic [5:0] mon_d_ff;
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) sel_ff <= 4'h0;
    else if (reg_wr_i && reg_addr_i == 8'h47) sel_ff <= reg_wdata_i[3:0];
    sel_d_ff <= sel_ff;
    mon_d_ff <= monitor_sig_i;
  end
  default clocking dc @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  sequence wr_s(logic [7:0] a);
    reg_wr_i && reg_addr_i == a;
  endsequence
  oe_follow_a: assert property (wr_s(8'h44) |-> ##2
    pin_oe_o[7:4] == ($past(reg_wdata_i[7:4], 2) | 4'h4)) else $error("oe mismatch");
  out_follow_a: assert property (wr_s(8'h45) |-> ##2
    pin_out_o[5:0] == $past(reg_wdata_i[5:0], 2)) else $error("out mismatch");
  gpio_flag_a: assert property (wr_s(8'h44) |=>
    clock_pin_gpio_enable_o == $past(reg_wdata_i[6])) else $error("gpio flag");
  pad_speed_a: assert property (wr_s(8'h47) |=>
    fast_pad_switching_o == $past(reg_wdata_i[7])) else $error("pad speed");
  scan_mask_a: assert property (boundary_scan_active_i && $past(boundary_scan_active_i)
    |-> pin_oe_o[3:0] == 4'h0) else $error("scan mask");
  clock_pin_a: assert property (!clock_pin_gpio_enable_o && !$past(clock_pin_gpio_enable_o)
    && !$past(srst_i) |-> pin_oe_o[6] && pin_out_o[6] == $past(clock_output_i))
    else $error("clock pin");
  revision_read_a: assert property (reg_rd_i && reg_addr_i == 8'h7F |=>
    reg_rdata_o == {SILICON_VERSION, SILICON_SUBVERSION}) else $error("revision");
  rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00) else $error("rdata idle");
  mon_fixed_a: assert property (sel_d_ff inside {4'h2, 4'h3} |-> debug_output_pin_oe_o
    && debug_output_pin_o == sel_d_ff[0]) else $error("fixed level");
  mon_tri_a: assert property (sel_d_ff < 4'h2 || sel_d_ff > 4'h9 |->
    !debug_output_pin_oe_o) else $error("tristate");
  mon_signal_a: assert property (sel_d_ff inside {[4'h4:4'h9]} |-> debug_output_pin_oe_o
    && debug_output_pin_o == mon_d_ff[4'h9 - sel_d_ff]) else $error("monitor");
endmodule : pin_reuse_gpio_checker
bind pin_reuse_gpio pin_reuse_gpio_checker #(.SILICON_VERSION(SILICON_VERSION),
  .SILICON_SUBVERSION(SILICON_SUBVERSION)) chk_i (.sys_clk_i, .srst_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .pin_out_o, .pin_oe_o,
  .boundary_scan_active_i, .clock_output_i, .clock_pin_gpio_enable_o, .monitor_sig_i,
  .debug_output_pin_o, .debug_output_pin_oe_o, .fast_pad_switching_o);

// File: testbench/pin_reuse_gpio_tb.sv
// Testbench: random register and pin traffic on the multi-use pin block
`timescale 1ns/1ps
module pin_reuse_gpio_tb;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, pin_in = 8'h00, rdata, pin_out, pin_oe, e, v, c;
  logic wr = 1'b0, rd = 1'b0, scan = 1'b0, clk_out = 1'b0, gpio_en, dbg, dbg_oe, fast;
  logic [5:0] mon = 6'h00;
  int n_mismatch = 0, samples_checked = 0;
  always #12.5 sys_clk_i = ~sys_clk_i;
  pin_reuse_gpio uut (.sys_clk_i, .srst_i, .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .pin_in_i(pin_in), .pin_out_o(pin_out),
    .pin_oe_o(pin_oe), .boundary_scan_active_i(scan), .clock_output_i(clk_out),
    .clock_pin_gpio_enable_o(gpio_en), .monitor_sig_i(mon), .debug_output_pin_o(dbg),
    .debug_output_pin_oe_o(dbg_oe), .fast_pad_switching_o(fast));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [7:0] s, logic [7:0] x);
    samples_checked++;
    if (s !== x) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask : wr_reg
  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd_chk(string nm, logic [7:0] a, logic [7:0] x);
    @(posedge sys_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1 chk(nm, rdata, x);
  endtask : rd_chk
  // Expected {drive enable, level} of the debug pin
  function automatic logic [1:0] exp_dbg(logic [3:0] s, logic [5:0] m);
    case (s)
      4'h2, 4'h3: return {1'b1, s[0]};
      4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9: return {1'b1, m[4'h9 - s]};
      default: return 2'b00;
    endcase
  endfunction : exp_dbg
  task automatic tally_and_finish;
    if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    e = 8'($urandom(4));
    repeat (12) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    rd_chk("enable_rst", 8'h44, 8'h00);
    rd_chk("control_rst", 8'h47, 8'h00);
    for (int i = 0; i < 32; i++) begin
      @(posedge sys_clk_i);
      pin_in <= 8'($urandom);
      scan <= 1'($urandom);
      clk_out <= 1'($urandom);
      mon <= 6'($urandom);
      e = 8'($urandom);
      v = 8'($urandom);
      c = {4'($urandom), i[3:0]};
      wr_reg(8'h44, e);
      wr_reg(8'h45, v);
      wr_reg(8'h47, c);
      wr_reg(8'h46, ~pin_in);
      wr_reg(8'h7F, 8'h00);
      rd_chk("enable", 8'h44, e);
      rd_chk("value", 8'h45, v);
      rd_chk("control", 8'h47, c & 8'h8F);
      rd_chk("input", 8'h46, pin_in);
      rd_chk("revision", 8'h7F,
             {pin_reuse_pkg::SILICON_VERSION_DEF, pin_reuse_pkg::SILICON_SUBVERSION_DEF});
      rd_chk("unmapped", 8'($urandom_range(8'h48, 8'h7E)), 8'h00);
      chk("oe", pin_oe, (e | 8'h40) & (scan ? 8'hF0 : 8'hFF));
      chk("out", pin_out, e[6] ? v : {v[7], clk_out, v[5:0]});
      chk("gpio", {7'h00, gpio_en}, {7'h00, e[6]});
      chk("fast", {7'h00, fast}, {7'h00, c[7]});
      chk("debug", {6'h00, dbg_oe, dbg & dbg_oe}, {6'h00, exp_dbg(c[3:0], mon)});
    end
    tally_and_finish();
  end
endmodule : pin_reuse_gpio_tb
